// file: bclog_pkg.sv
// package for the brushless commutation logic: register map, types, timing
package bclog_pkg;

   // register byte offsets
   localparam logic [3:0] BCLOG_OFS_CTRL   = 4'h0; // control bits
   localparam logic [3:0] BCLOG_OFS_STATUS = 4'h4; // live state, read only
   localparam logic [3:0] BCLOG_OFS_IRQ    = 4'h8; // sticky events, read clears
   localparam logic [3:0] BCLOG_OFS_MASK   = 4'hC; // interrupt mask

   // control register field positions
   localparam int BCLOG_CTRL_RUN   = 0;          // run enable
   localparam int BCLOG_CTRL_DIR   = 1;          // direction select
   localparam int BCLOG_CTRL_PH60  = 2;          // 60 degree phasing
   localparam int BCLOG_CTRL_BRAKE = 3;          // brake request
   localparam logic [3:0] BCLOG_CTRL_RST = 4'h9; // brake on, run on

   // event bit positions (irq and mask)
   localparam int BCLOG_EV_FAULT = 0; // fault asserted
   localparam int BCLOG_EV_ILIM  = 1; // current limit tripped
   localparam int BCLOG_EV_BADS  = 2; // invalid sensor code seen
   localparam int BCLOG_EV_W     = 3; // number of events

   // axi answers
   localparam logic [1:0] BCLOG_RESP_OKAY   = 2'h0;
   localparam logic [1:0] BCLOG_RESP_SLVERR = 2'h2;

   // oscillator timing
   localparam int BCLOG_CLK_HZ     = 100_000_000;          // aclk rate
   localparam int BCLOG_OSC_HZ     = 25_000;               // pwm cycle rate
   localparam int BCLOG_OSC_CYCLES = BCLOG_CLK_HZ / BCLOG_OSC_HZ;

   // drive outputs: three top, three bottom, phase order a b c
   typedef struct packed
   {
      logic [2:0] top; // top drives, high = conducting
      logic [2:0] bot; // bottom drives, high = conducting
   } bclog_drive_s;

   // axi-lite slave state machine
   typedef enum logic [2:0]
   {
      BCLOG_AX_IDLE = 3'b001, // waiting for requests
      BCLOG_AX_BRSP = 3'b010, // write answer pending
      BCLOG_AX_RRSP = 3'b100  // read answer pending
   } bclog_ax_e;

endpackage : bclog_pkg

// file: bclog_top.sv
// brushless commutation logic with axi4-lite control and fault reporting
// Functional notes
// - sensor code selects top and bottom drives
// - direction change reverses drive pattern
// - run enable high sequences, low coasts
// - phasing select picks 60 or 120 decode
// - brake high stops and decelerates motor
// - current limit ends conduction this cycle
// - fault low on listed fault conditions
// - braking: tops off, bottoms all on
// - brake overrides every other input
// - reverse swaps top and bottom per phase
// - disabled: tops off, bottoms forced low
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps

module bclog_top
   import bclog_pkg::*;
#(
   parameter int OSC_CYCLES = bclog_pkg::BCLOG_OSC_CYCLES // clocks per cycle
)
(
   input  wire logic         aclk,           // 100 mhz clock
   input  wire logic         aresetn,        // sync reset, active low
   input  wire logic [3:0]   s_axi_awaddr,   // write address
   input  wire logic         s_axi_awvalid,  // write address valid
   output logic              s_axi_awready,  // write address ready
   input  wire logic [31:0]  s_axi_wdata,    // write data
   input  wire logic [3:0]   s_axi_wstrb,    // write byte strobes
   input  wire logic         s_axi_wvalid,   // write data valid
   output logic              s_axi_wready,   // write data ready
   output logic [1:0]        s_axi_bresp,    // write answer code
   output logic              s_axi_bvalid,   // write answer valid
   input  wire logic         s_axi_bready,   // write answer ready
   input  wire logic [3:0]   s_axi_araddr,   // read address
   input  wire logic         s_axi_arvalid,  // read address valid
   output logic              s_axi_arready,  // read address ready
   output logic [31:0]       s_axi_rdata,    // read data
   output logic [1:0]        s_axi_rresp,    // read answer code
   output logic              s_axi_rvalid,   // read answer valid
   input  wire logic         s_axi_rready,   // read answer ready
   input  wire logic [2:0]   sensor_in,      // rotor sensors a b c
   input  wire logic         ilim_in,        // current sense at threshold
   input  wire logic         uvlo_in,        // undervoltage lockout active
   input  wire logic         tsd_in,         // thermal shutdown active
   output bclog_drive_s      drive,          // bridge drive outputs
   output logic              fault_n,        // fault, active low
   output logic              irq             // level interrupt
);

   ////////////////////////////////////////////////////////////////////////
   // elaboration checks; a cycle of one clock would leave the
   // current limit latch no room to hold conduction off at all

   if (OSC_CYCLES < 2)
   begin : g_bad_osc
      $error("OSC_CYCLES must be at least 2");
   end

   localparam int CW = $clog2(OSC_CYCLES); // cycle counter width
   localparam logic [CW-1:0] OSC_LAST = CW'(OSC_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////
   // decode helpers

   // 120 degree decode: one top and one bottom per valid code, forward
   function automatic bclog_drive_s dec120(input logic [2:0] s);
      bclog_drive_s d;
      d = '{top: 3'h0, bot: 3'h0};
      unique case (s)
         3'h4: d = '{top: 3'h4, bot: 3'h2}; // a top, b bottom
         3'h6: d = '{top: 3'h4, bot: 3'h1}; // a top, c bottom
         3'h2: d = '{top: 3'h2, bot: 3'h1}; // b top, c bottom
         3'h3: d = '{top: 3'h2, bot: 3'h4}; // b top, a bottom
         3'h1: d = '{top: 3'h1, bot: 3'h4}; // c top, a bottom
         3'h5: d = '{top: 3'h1, bot: 3'h2}; // c top, b bottom
         default: d = '{top: 3'h0, bot: 3'h0}; // 000, 111 invalid
      endcase
      return d;
   endfunction : dec120

   // map 60 degree code onto the equivalent 120 degree code;
   // the middle sensor reads inverted in that convention
   function automatic logic [2:0] to120(input logic [2:0] s, input logic p60);
      return p60 ? {s[2], ~s[1], s[0]} : s;
   endfunction : to120

   // invalid code: all sensors equal
   function automatic logic bad_code(input logic [2:0] s);
      return (s == 3'h0) || (s == 3'h7);
   endfunction : bad_code

   ////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed
   {
      logic [2:0]           sens_m;   // sensor sync, first stage
      logic [2:0]           sens_s;   // sensor sync, second stage
      logic                 ilim_m;   // current limit sync, first
      logic                 ilim_s;   // current limit sync, second
      logic                 uvlo_m;   // uvlo sync, first
      logic                 uvlo_s;   // uvlo sync, second
      logic                 tsd_m;    // thermal sync, first
      logic                 tsd_s;    // thermal sync, second
      logic [CW-1:0]        osc;      // oscillator cycle counter
      logic                 ilim_lat; // conduction cut this cycle
      logic [3:0]           ctrl;     // control register
      logic [BCLOG_EV_W-1:0] ev;      // sticky events
      logic [BCLOG_EV_W-1:0] mask;    // interrupt mask
      logic                 flt_prev; // fault level last cycle
      bclog_ax_e            ax;       // bus state
      logic                 aw_got;   // write address held
      logic                 w_got;    // write data held
      logic [3:0]           awaddr;   // held write address
      logic [31:0]          wdata;    // held write data
      logic [3:0]           wstrb;    // held strobes
      logic                 awready;  // bus outputs
      logic                 wready;
      logic                 arready;
      logic                 bvalid;
      logic [1:0]           bresp;
      logic                 rvalid;
      logic [1:0]           rresp;
      logic [31:0]          rdata;
      bclog_drive_s         drv;      // drive outputs
      logic                 fault_n;  // fault output
      logic                 irq;      // interrupt output
   } bclog_state_s;

   bclog_state_s st_q; // registered state
   bclog_state_s st_d; // next state

   ////////////////////////////////////////////////////////////////////////
   // next state logic

   always_comb
   begin
      bclog_drive_s          pat;     // decoded pattern
      logic [2:0]            code;    // code after phasing map
      logic                  fault;   // any fault condition
      logic [BCLOG_EV_W-1:0] hit;     // events this cycle
      logic                  cyc_end; // last clock of osc cycle
      logic                  rd_irq;  // irq register read now
      logic                  do_wr;   // write commits now
      pat     = '{top: 3'h0, bot: 3'h0};
      code    = 3'h0;
      fault   = 1'b0;
      hit     = '0;
      cyc_end = 1'b0;
      rd_irq  = 1'b0;
      do_wr   = 1'b0;
      st_d    = st_q;

      // two-flop synchronisers for pins; every pin is asynchronous to
      // aclk, so only the second stage feeds logic, at the cost of
      // two clocks of latency on every reaction
      st_d.sens_m = sensor_in;
      st_d.sens_s = st_q.sens_m;
      st_d.ilim_m = ilim_in;
      st_d.ilim_s = st_q.ilim_m;
      st_d.uvlo_m = uvlo_in;
      st_d.uvlo_s = st_q.uvlo_m;
      st_d.tsd_m  = tsd_in;
      st_d.tsd_s  = st_q.tsd_m;

      // free running oscillator; it only marks where one conduction
      // cycle ends and the next begins, so it never stops, not even
      // under brake or while disabled
      cyc_end = (st_q.osc == OSC_LAST);
      st_d.osc = cyc_end ? '0 : st_q.osc + CW'(1);

      // latch holds off conduction until the cycle wraps, then it
      // re-arms; a limit still present re-latches at once
      if (st_q.ilim_s)
         st_d.ilim_lat = 1'b1;
      else if (cyc_end)
         st_d.ilim_lat = 1'b0;

      // commutation decode; the phasing map comes first so that
      // validity, table and fault all see one and the same code
      code = to120(st_q.sens_s, st_q.ctrl[BCLOG_CTRL_PH60]);
      pat  = dec120(code);
      if (!st_q.ctrl[BCLOG_CTRL_DIR])
         pat = '{top: pat.bot, bot: pat.top};

      // priority: brake, then enable, then limit; brake wins even
      // over a missing enable, being the safe state on power up
      if (st_q.ctrl[BCLOG_CTRL_BRAKE])
         st_d.drv = '{top: 3'h0, bot: 3'h7};
      else if (!st_q.ctrl[BCLOG_CTRL_RUN])
         st_d.drv = '{top: 3'h0, bot: 3'h0};
      else if (st_q.ilim_lat || st_q.ilim_s)
         st_d.drv = '{top: 3'h0, bot: 3'h0};
      else
         st_d.drv = pat;

      // fault output; an invalid code is judged after the phasing map,
      // since 000 and 111 are real rotor positions in 60 degree mode
      fault = bad_code(code) || !st_q.ctrl[BCLOG_CTRL_RUN]
              || st_q.ilim_s || st_q.uvlo_s || st_q.tsd_s;
      st_d.fault_n  = !fault;
      st_d.flt_prev = fault;

      // events; the fault bit takes the rising level only, so a fault
      // that stands for long raises one event, not one per clock
      hit[BCLOG_EV_FAULT] = fault && !st_q.flt_prev;
      hit[BCLOG_EV_ILIM]  = st_q.ilim_s && !st_q.ilim_lat;
      hit[BCLOG_EV_BADS]  = bad_code(code);

      // bus: answers retire first; only one write or one read is
      // ever in flight, so a single state word is enough here
      if (st_q.bvalid && s_axi_bready)
         st_d.bvalid = 1'b0;
      if (st_q.rvalid && s_axi_rready)
         st_d.rvalid = 1'b0;
      st_d.awready = 1'b0;
      st_d.wready  = 1'b0;
      st_d.arready = 1'b0;

      unique case (st_q.ax)
         BCLOG_AX_IDLE:
         begin
            // capture address and data in either order
            if (s_axi_awvalid && !st_q.aw_got && !st_q.awready)
            begin
               st_d.awready = 1'b1;
               st_d.aw_got  = 1'b1;
               st_d.awaddr  = s_axi_awaddr;
            end
            if (s_axi_wvalid && !st_q.w_got && !st_q.wready)
            begin
               st_d.wready = 1'b1;
               st_d.w_got  = 1'b1;
               st_d.wdata  = s_axi_wdata;
               st_d.wstrb  = s_axi_wstrb;
            end
            if (st_q.aw_got && st_q.w_got)
            begin
               do_wr        = 1'b1;
               st_d.aw_got  = 1'b0;
               st_d.w_got   = 1'b0;
               st_d.bvalid  = 1'b1;
               st_d.bresp   = BCLOG_RESP_OKAY;
               st_d.ax      = BCLOG_AX_BRSP;
            end
            else if (s_axi_arvalid && !st_q.arready)
            begin
               // reads served unless address and data of a write are both held
               st_d.arready = 1'b1;
               st_d.rvalid  = 1'b1;
               st_d.rresp   = BCLOG_RESP_OKAY;
               st_d.ax      = BCLOG_AX_RRSP;
               unique case (s_axi_araddr)
                  BCLOG_OFS_CTRL:   st_d.rdata = {28'h0, st_q.ctrl};
                  BCLOG_OFS_STATUS: st_d.rdata = {24'h0, st_q.drv,
                                                  st_q.fault_n,
                                                  st_q.ilim_lat};
                  BCLOG_OFS_IRQ:
                  begin
                     st_d.rdata = {29'h0, st_q.ev};
                     rd_irq     = 1'b1;
                  end
                  BCLOG_OFS_MASK:   st_d.rdata = {29'h0, st_q.mask};
                  default:
                  begin
                     st_d.rdata = 32'h0;
                     st_d.rresp = BCLOG_RESP_SLVERR;
                  end
               endcase
            end
         end
         BCLOG_AX_BRSP:
            if (st_q.bvalid && s_axi_bready)
               st_d.ax = BCLOG_AX_IDLE;
         BCLOG_AX_RRSP:
            if (st_q.rvalid && s_axi_rready)
               st_d.ax = BCLOG_AX_IDLE;
         default:
            st_d.ax = BCLOG_AX_IDLE;
      endcase

      // register writes, low byte carries every field; a ctrl or mask
      // write with byte lane 0 off is dropped whole but still answered okay
      if (do_wr)
      begin
         if (st_q.awaddr == BCLOG_OFS_CTRL && st_q.wstrb[0])
            st_d.ctrl = st_q.wdata[3:0];
         else if (st_q.awaddr == BCLOG_OFS_MASK && st_q.wstrb[0])
            st_d.mask = st_q.wdata[BCLOG_EV_W-1:0];
         else if (st_q.awaddr != BCLOG_OFS_CTRL
                  && st_q.awaddr != BCLOG_OFS_STATUS
                  && st_q.awaddr != BCLOG_OFS_IRQ
                  && st_q.awaddr != BCLOG_OFS_MASK)
            st_d.bresp = BCLOG_RESP_SLVERR;
      end

      // sticky events: a new event wins over the read clear, so an
      // event landing in the very cycle of the read is not lost;
      // the mask comes from the register, a fresh write acts next
      st_d.ev  = (rd_irq ? '0 : st_q.ev) | hit;
      st_d.irq = |(st_d.ev & st_q.mask);

      // reset puts the bridge into brake with all tops off, the one
      // pattern that is safe whatever the rotor happens to be doing
      if (!aresetn)
      begin
         st_d          = '0;
         st_d.ax       = BCLOG_AX_IDLE;
         st_d.ctrl     = BCLOG_CTRL_RST;
         st_d.drv      = '{top: 3'h0, bot: 3'h7};
         st_d.fault_n  = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register; every field of the block lives here, so the
   // synchronous reset above reaches all of it in one place

   always_ff @(posedge aclk)
   begin
      st_q <= st_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs, all straight from flops; the drive pins thus never
   // glitch while the decode settles between clock edges

   assign s_axi_awready = st_q.awready;
   assign s_axi_wready  = st_q.wready;
   assign s_axi_bvalid  = st_q.bvalid;
   assign s_axi_bresp   = st_q.bresp;
   assign s_axi_arready = st_q.arready;
   assign s_axi_rvalid  = st_q.rvalid;
   assign s_axi_rresp   = st_q.rresp;
   assign s_axi_rdata   = st_q.rdata;
   assign drive         = st_q.drv;
   assign fault_n       = st_q.fault_n;
   assign irq           = st_q.irq;

endmodule : bclog_top

// file: bclog_chk.sv
// port assertions for the brushless commutation logic
`timescale 1ns/1ps

module bclog_chk
   import bclog_pkg::*;
(
   input wire logic         aclk,          // clock
   input wire logic         aresetn,       // reset, active low
   input wire logic         s_axi_awvalid, // write address valid
   input wire logic         s_axi_awready, // write address ready
   input wire logic [1:0]   s_axi_bresp,   // write answer code
   input wire logic         s_axi_bvalid,  // write answer valid
   input wire logic         s_axi_bready,  // write answer ready
   input wire logic         s_axi_arvalid, // read address valid
   input wire logic         s_axi_arready, // read address ready
   input wire logic [31:0]  s_axi_rdata,   // read data
   input wire logic [1:0]   s_axi_rresp,   // read answer code
   input wire logic         s_axi_rvalid,  // read answer valid
   input wire logic         s_axi_rready,  // read answer ready
   input wire logic         ilim_in,       // current sense at threshold
   input wire logic         uvlo_in,       // undervoltage lockout
   input wire logic         tsd_in,        // thermal shutdown
   input wire bclog_drive_s drive,         // bridge drives
   input wire logic         fault_n        // fault, active low
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // six samples cover the two sync flops plus output stage
   sequence s_lockout;
      (uvlo_in || tsd_in) [*6];
   endsequence
   sequence s_ilim;
      ilim_in [*6];
   endsequence
   sequence s_aw_take;
      s_axi_awvalid && s_axi_awready;
   endsequence
   sequence s_ar_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   property p_top_onehot;
      $onehot0(drive.top);
   endproperty
   property p_leg_pair;
      drive.top != 3'h0 |-> $onehot(drive.bot) && !(|(drive.top & drive.bot));
   endproperty
   property p_brake_bots;
      drive.top == 3'h0 && drive.bot != 3'h0 |-> drive.bot == 3'h7;
   endproperty
   property p_lockout;
      s_lockout |-> !fault_n;
   endproperty
   property p_ilim;
      s_ilim |-> drive.top == 3'h0 && !fault_n;
   endproperty
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=>
         s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
   endproperty
   property p_wr_resp;
      s_aw_take |-> ##[1:8] s_axi_bvalid;
   endproperty
   property p_rd_resp;
      s_ar_take |-> ##[0:2] s_axi_rvalid;
   endproperty
   a_top_onehot: assert property (p_top_onehot)
      else $error("more than one top drive on");
   a_leg_pair: assert property (p_leg_pair)
      else $error("bottom drive does not pair with top drive");
   a_brake_bots: assert property (p_brake_bots)
      else $error("partial bottom drive with tops off");
   a_lockout: assert property (p_lockout)
      else $error("fault not shown during lockout");
   a_ilim: assert property (p_ilim)
      else $error("conduction during current limit");
   a_bhold: assert property (p_bhold)
      else $error("write answer dropped before bready");
   a_rhold: assert property (p_rhold)
      else $error("read answer changed before rready");
   a_wr_resp: assert property (p_wr_resp)
      else $error("write answer missing");
   a_rd_resp: assert property (p_rd_resp)
      else $error("read answer missing");
endmodule : bclog_chk

bind bclog_top bclog_chk u_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .ilim_in(ilim_in), .uvlo_in(uvlo_in), .tsd_in(tsd_in),
   .drive(drive), .fault_n(fault_n)
);

// file: bclog_motor.sv
// rotor model: hall codes out, bridge drives watched for shoot-through
`timescale 1ns/1ps

module bclog_motor
   import bclog_pkg::*;
(
   input  wire logic         aclk,    // clock
   input  wire logic         aresetn, // reset, active low
   input  wire logic         step,    // advance one sector
   input  wire logic         bad,     // open or shorted sensor line
   input  wire bclog_drive_s drive,   // bridge drives from the block
   output logic [2:0]        hall,    // sensor levels a b c
   output logic              shorted  // both switches of a leg seen on
);
   localparam logic [2:0] SEQ [6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};
   logic [2:0] pos_q; // rotor sector 0..5
   // broken lines all read 111 in odd sectors, 000 in even sectors
   always_comb
      hall = bad ? {3{pos_q[0]}} : SEQ[pos_q];
   // sector counter and leg short watch
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         pos_q <= 3'h0;
         shorted <= 1'b0;
      end
      else
      begin
         if (step) pos_q <= (pos_q == 3'h5) ? 3'h0 : pos_q + 3'h1;
         if (|(drive.top & drive.bot)) shorted <= 1'b1;
      end
endmodule : bclog_motor

// file: bclog_top_tb.sv
// self-checking bench for the brushless commutation logic
`timescale 1ns/1ps

module bclog_top_tb;
   import bclog_pkg::*;
   localparam int OSC = 8; // short oscillator cycle keeps the run brief
   localparam logic [3:0] CS [4] = '{4'h6, 4'hC, 4'hA, 4'hB}; // stop cases
   logic         aclk = 1'b0, aresetn = 1'b0;          // clock, reset
   logic [3:0]   awa = 4'h0, ara = 4'h0, stb = 4'hF;   // addresses, strobes
   logic [31:0]  wd = 32'h0, rnd = 32'h000144E2;       // data, lfsr state
   logic         awv = 1'b0, wv = 1'b0, brd = 1'b0;    // write handshakes
   logic         arv = 1'b0, rrd = 1'b0, step = 1'b0;  // read, rotor step
   logic         ilim = 1'b0, uvlo = 1'b0, tsd = 1'b0; // protection pins
   logic         bad = 1'b0;                           // broken sensor
   logic         awr, wrd, bv, arr, rv, flt_n, irq, shorted; // outputs
   logic [1:0]   br, rr;                               // answer codes
   logic [31:0]  rdt;                                  // read data
   logic [2:0]   hall;                                 // sensor levels
   logic [3:0]   ctrl;                                 // control mirror
   bclog_drive_s drv;                                  // bridge drives
   logic [34:0]  q[$], e;                              // expected reads
   int           err_count = 0, checked = 0;           // tallies
   bclog_top #(.OSC_CYCLES(OSC)) u_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(stb), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rrd), .sensor_in(hall), .ilim_in(ilim),
      .uvlo_in(uvlo), .tsd_in(tsd), .drive(drv), .fault_n(flt_n),
      .irq(irq));
   bclog_motor u_mot (.aclk(aclk), .aresetn(aresetn), .step(step),
      .bad(bad), .drive(drv), .hall(hall), .shorted(shorted));
   always #5 aclk = ~aclk;
   ////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr
   // expected status word: {drive, fault_n, latched limit}
   function automatic logic [34:0] exp_st(logic [2:0] s, logic [3:0] c,
                                          logic il);
      logic [5:0] r;
      logic       f;
      s[1] = s[1] ^ c[BCLOG_CTRL_PH60];
      f = !(s == 3'h0 || s == 3'h7 || !c[BCLOG_CTRL_RUN] || il);
      case (s)
         3'h4: r = 6'h22;
         3'h6: r = 6'h21;
         3'h2: r = 6'h11;
         3'h3: r = 6'h14;
         3'h1: r = 6'h0C;
         3'h5: r = 6'h0A;
         default: r = 6'h00;
      endcase
      if (!c[BCLOG_CTRL_DIR]) r = {r[2:0], r[5:3]};
      if (!c[BCLOG_CTRL_RUN] || il) r = 6'h00;
      if (c[BCLOG_CTRL_BRAKE]) r = 6'h07;
      return {27'h0, r, f, il};
   endfunction : exp_st
   task automatic end_sim();
      $display("mismatches %0d comparisons %0d", err_count, checked);
      if (err_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [34:0] got, input logic [34:0] exp);
      checked++;
      if (got !== exp)
      begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         err_count++;
      end
   endtask : chk
   // write: both channels offered together, bready up from the start
   task automatic wr(input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      int n;
      @(posedge aclk);
      n = 0;
      awa <= a;
      wd <= d;
      stb <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      brd <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
         n++;
      end
      while (!bv && n < 60);
      if (n >= 60) err_count++;
      if (n >= 60) end_sim();
      chk(35'(br), 35'(BCLOG_RESP_OKAY));
      brd <= 1'b0;
   endtask : wr
   // read: note expectation, rready held up until rvalid is seen
   task automatic rd(input logic [3:0] a, input logic [34:0] x);
      int n;
      @(posedge aclk);
      q.push_back(x);
      n = 0;
      ara <= a;
      arv <= 1'b1;
      rrd <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arr) arv <= 1'b0;
         n++;
      end
      while (!rv && n < 60);
      if (n >= 60) err_count++;
      if (n >= 60) end_sim();
      rrd <= 1'b0;
   endtask : rd
   task automatic setc(input logic [3:0] c);
      ctrl = c;
      rnd = lfsr(rnd);
      wr(BCLOG_OFS_CTRL, {rnd[31:4], c}, 4'hF);
      rd(BCLOG_OFS_CTRL, {31'h0, c});
   endtask : setc
   task automatic st(input logic il);
      logic [34:0] x;
      repeat (6) @(posedge aclk);
      x = exp_st(hall, ctrl, il);
      chk({27'h0, drv, flt_n, 1'b0}, {x[34:1], 1'b0});
      rd(BCLOG_OFS_STATUS, x);
   endtask : st
   // read answers compared against the oldest note
   always @(posedge aclk)
      if (rv && rrd && q.size() > 0)
      begin
         e = q.pop_front();
         if (!e[34]) chk({1'b0, rr, rdt}, e);
      end
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      ctrl = BCLOG_CTRL_RST;
      rd(BCLOG_OFS_CTRL, {31'h0, ctrl});
      rd(BCLOG_OFS_MASK, 35'h0);
      rd(4'h2, {1'b0, BCLOG_RESP_SLVERR, 32'h0});
      st(1'b0);
      for (int c = 1; c < 8; c += 2)
      begin
         setc(4'(c));
         for (int p = 0; p < 8; p++)
         begin
            bad <= (p > 5);
            st(1'b0);
            @(posedge aclk);
            step <= 1'b1;
            @(posedge aclk);
            step <= 1'b0;
         end
      end
      bad <= 1'b0;
      wr(BCLOG_OFS_CTRL, 32'h0, 4'hE);
      rd(BCLOG_OFS_CTRL, {31'h0, ctrl});
      for (int i = 0; i < 4; i++)
      begin
         setc(CS[i]);
         st(1'b0);
      end
      setc(4'h3);
      for (int i = 1; i < 3; i++)
      begin
         {uvlo, tsd} <= 2'(i);
         repeat (6) @(posedge aclk);
         chk(35'(flt_n), 35'h0);
      end
      {uvlo, tsd} <= 2'h0;
      repeat (6) @(posedge aclk);
      rd(BCLOG_OFS_IRQ, {1'b1, 34'h0});
      wr(BCLOG_OFS_MASK, 32'h2, 4'hF);
      rd(BCLOG_OFS_MASK, 35'h2);
      ilim <= 1'b1;
      st(1'b1);
      chk(35'(irq), 35'h1);
      ilim <= 1'b0;
      repeat (2 * OSC) @(posedge aclk);
      st(1'b0);
      rd(BCLOG_OFS_IRQ, 35'h3);
      repeat (3) @(posedge aclk);
      chk(35'(irq), 35'h0);
      rd(BCLOG_OFS_IRQ, 35'h0);
      uvlo <= 1'b1;
      repeat (6) @(posedge aclk);
      uvlo <= 1'b0;
      repeat (6) @(posedge aclk);
      chk(35'(irq), 35'h0);
      rd(BCLOG_OFS_IRQ, 35'h1);
      chk(35'(shorted), 35'h0);
      end_sim();
   end
endmodule : bclog_top_tb
